// ==== verilog/fsu_cfg.svh ====
// register map, field positions, reset values and timing for frequency slaving
`ifndef FSU_CFG_SVH
`define FSU_CFG_SVH

`define FSU_ADDR_CTRL        8'h00
`define FSU_ADDR_NUM         8'h04
`define FSU_ADDR_DEN         8'h08
`define FSU_ADDR_SLV_DEMAND  8'h0c
`define FSU_ADDR_FREQ_OUT    8'h10

`define FSU_CTRL_SLAVE_EN    0
`define FSU_CTRL_OUT_EN      1
`define FSU_CTRL_MULT        2
`define FSU_CTRL_FMT         3
`define FSU_CTRL_ENC_TYPE    4
`define FSU_CTRL_W           5

`define FSU_CTRL_RST         5'h00
`define FSU_RATIO_RST        16'h03e8
`define FSU_DEN_MIN          16'h0001

`define FSU_RESP_OKAY        2'h0
`define FSU_RESP_SLVERR      2'h2

`define FSU_CLK_MHZ          50
`define FSU_CLK_HZ           50000000
`define FSU_WIN_TIME_US      4000
`define FSU_WIN_CYC          (`FSU_WIN_TIME_US * `FSU_CLK_MHZ)
`define FSU_GAP_TIME_US      250
`define FSU_GAP_CYC          (`FSU_GAP_TIME_US * `FSU_CLK_MHZ)
`define FSU_TENTHS_PER_HZ    10
`define FSU_NCO_LIMIT        (`FSU_CLK_HZ * `FSU_TENTHS_PER_HZ)
`define FSU_COUNT_TO_TENTHS  2500
`define FSU_MULT_HI_SHIFT    12
`define FSU_MULT_LO_SHIFT    1

`endif

// ==== verilog/fsu_pkg.sv ====
// types shared by the frequency slaving unit
package fsu_pkg;

   typedef struct packed {
      logic enc_type;
      logic fmt;
      logic mult;
      logic out_en;
      logic slave_en;
   } fsu_ctrl_type;

   typedef struct packed {
      logic a;
      logic b;
   } fsu_pulse_type;

   typedef enum logic [0:0] {
      FSU_GEN_RUN = 1'b0,
      FSU_GEN_GAP = 1'b1
   } fsu_gen_type;

endpackage : fsu_pkg

// ==== verilog/fsu_top.sv ====
// frequency slaving unit: input decode, ratio scaling, demand, output pulses
//
// Implementation choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "fsu_cfg.svh"

module fsu_top #(
   parameter int ADDR_W     = 8,
   parameter int WIN_CYC    = `FSU_WIN_CYC,
   parameter int GAP_CYC    = `FSU_GAP_CYC,
   parameter int LINES_LOG2 = 12
) (
   input  wire logic                  clk_sys,
   input  wire logic                  arst_n,
   input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   output logic [1:0]                 s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   input  wire logic [ADDR_W-1:0]     s_axi_araddr,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   output logic [31:0]                s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   input  wire logic                  drive_enable,
   input  wire logic signed [15:0]    normal_demand,
   input  wire logic [15:0]           ramp_step,
   input  wire fsu_pkg::fsu_pulse_type enc_in,
   output fsu_pkg::fsu_pulse_type     pulse_out,
   output logic signed [15:0]         freq_out
);

   localparam int WIN_W = $clog2(WIN_CYC + 1);
   localparam int GAP_W = $clog2(GAP_CYC + 1);
   localparam logic [33:0] NCO_LIM = 34'(`FSU_NCO_LIMIT);

   fsu_pkg::fsu_ctrl_type   ctrl_reg;
   logic [15:0]             num_reg;
   logic [15:0]             den_reg;
   logic [ADDR_W-1:0]       awaddr_reg;
   logic [31:0]             wdata_reg;
   logic [3:0]              wstrb_reg;
   logic                    wr_go;
   logic [1:0]              enc_prev_reg;
   logic                    in_ev;
   logic                    in_rev;
   logic signed [23:0]      racc_reg;
   logic signed [23:0]      racc_next;
   logic signed [23:0]      den_s;
   logic                    sc_ev;
   logic                    sc_rev;
   logic [WIN_W-1:0]        win_cnt_reg;
   logic                    win_tick;
   logic signed [19:0]      cnt_reg;
   logic signed [19:0]      cnt_step;
   logic signed [15:0]      slv_dem_reg;
   logic signed [35:0]      dem_prod;
   logic signed [16:0]      ramp_diff;
   logic signed [16:0]      step_s;
   logic                    dir_reg;
   fsu_pkg::fsu_gen_type    gen_reg;
   logic [GAP_W-1:0]        gap_cnt_reg;
   logic [15:0]             freq_mag;
   logic [27:0]             nco_inc;
   logic [33:0]             nco_reg;
   logic [33:0]             nco_sum;
   logic                    edge_ev;
   logic                    reversal;
   logic [1:0]              quad_reg;
   logic                    fd_reg;
   function automatic logic [15:0] fsu_merge16(input logic [15:0] old,
                                               input logic [31:0] data,
                                               input logic [3:0]  strb);
      logic [15:0] res;
      res = old;
      for (int i = 0; i < 2; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = data[i*8 +: 8];
         end
      end
      return res;
   endfunction : fsu_merge16
   function automatic logic signed [15:0] fsu_sat16(
      input logic signed [35:0] v);
      logic signed [15:0] res;
      res = v[15:0];
      if (v > 36'sh000007fff) begin
         res = 16'sh7fff;
      end else if (v < -36'sh000007fff) begin
         res = -16'sh7fff;
      end
      return res;
   endfunction : fsu_sat16
   // axi4-lite write channel
   assign wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `FSU_RESP_OKAY;
         awaddr_reg    <= '0;
         wdata_reg     <= '0;
         wstrb_reg     <= '0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            awaddr_reg    <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            wdata_reg    <= s_axi_wdata;
            wstrb_reg    <= s_axi_wstrb;
         end
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (awaddr_reg[7:0] inside {`FSU_ADDR_CTRL,
                            `FSU_ADDR_NUM, `FSU_ADDR_DEN}) ? `FSU_RESP_OKAY
                                                           : `FSU_RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end
   // ratio terms may be rewritten while running; residue is kept
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_reg <= `FSU_CTRL_RST;
         num_reg  <= `FSU_RATIO_RST;
         den_reg  <= `FSU_RATIO_RST;
      end else if (wr_go) begin
         case (awaddr_reg[7:0])
            `FSU_ADDR_CTRL: begin
               if (wstrb_reg[0]) begin
                  ctrl_reg <= wdata_reg[`FSU_CTRL_W-1:0];
               end
            end
            `FSU_ADDR_NUM: begin
               num_reg <= fsu_merge16(num_reg, wdata_reg, wstrb_reg);
            end
            `FSU_ADDR_DEN: begin
               den_reg <= fsu_merge16(den_reg, wdata_reg, wstrb_reg);
            end
            default: ctrl_reg <= ctrl_reg;
         endcase
      end
   end
   // axi4-lite read channel
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= `FSU_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rresp   <= `FSU_RESP_OKAY;
         case (s_axi_araddr[7:0])
            `FSU_ADDR_CTRL: s_axi_rdata <= {27'h0000000, ctrl_reg};
            `FSU_ADDR_NUM: s_axi_rdata <= {16'h0000, num_reg};
            `FSU_ADDR_DEN: s_axi_rdata <= {16'h0000, den_reg};
            `FSU_ADDR_SLV_DEMAND: begin
               s_axi_rdata <= {{16{slv_dem_reg[15]}}, slv_dem_reg};
            end
            `FSU_ADDR_FREQ_OUT: s_axi_rdata <= {{16{freq_out[15]}}, freq_out};
            default: begin
               s_axi_rdata <= 32'h00000000;
               s_axi_rresp <= `FSU_RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end
   // slaving input decode
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         enc_prev_reg <= 2'h0;
      end else begin
         enc_prev_reg <= {enc_in.a, enc_in.b};
      end
   end
   // quad forward order 00-01-11-10; in f and d mode b high means reverse
   always_comb begin
      in_ev  = 1'b0;
      in_rev = 1'b0;
      if (ctrl_reg.enc_type) begin
         in_ev  = enc_in.a && !enc_prev_reg[1];
         in_rev = enc_in.b;
      end else begin
         case ({enc_prev_reg, enc_in.a, enc_in.b})
            4'h1, 4'h7, 4'he, 4'h8: begin
               in_ev = 1'b1;
            end
            4'h2, 4'hb, 4'hd, 4'h4: begin
               in_ev  = 1'b1;
               in_rev = 1'b1;
            end
            default: begin
               in_ev = 1'b0;
            end
         endcase
      end
   end
   // ratio scaling with a kept residue
   // one scaled count leaves per clock; ratios far above one lag behind
   always_comb begin
      den_s     = (den_reg == 16'h0000) ? 24'(`FSU_DEN_MIN)
                                        : 24'(den_reg);
      racc_next = racc_reg;
      sc_ev     = 1'b0;
      sc_rev    = 1'b0;
      if (drive_enable) begin
         if (in_ev) begin
            racc_next = in_rev ? racc_reg - 24'(num_reg)
                               : racc_reg + 24'(num_reg);
         end
         if (racc_next >= den_s) begin
            racc_next = racc_next - den_s;
            sc_ev     = 1'b1;
         end else if (racc_next <= -den_s) begin
            racc_next = racc_next + den_s;
            sc_ev     = 1'b1;
            sc_rev    = 1'b1;
         end
      end
   end
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         racc_reg <= '0;
      end else begin
         racc_reg <= racc_next;
      end
   end
   // 4 ms measurement window and slave demand
   assign win_tick = (win_cnt_reg == WIN_W'(WIN_CYC - 1));
   assign cnt_step = sc_ev ? (sc_rev ? -20'sd1 : 20'sd1) : 20'sd0;
   assign dem_prod = 36'(cnt_reg) * 36'(`FSU_COUNT_TO_TENTHS);
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         win_cnt_reg <= '0;
         cnt_reg     <= '0;
      end else if (win_tick) begin
         win_cnt_reg <= '0;
         cnt_reg     <= cnt_step;
      end else begin
         win_cnt_reg <= win_cnt_reg + WIN_W'(1);
         cnt_reg     <= cnt_reg + cnt_step;
      end
   end
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         slv_dem_reg <= '0;
      end else if (!drive_enable) begin
         slv_dem_reg <= '0;
      end else if (win_tick) begin
         slv_dem_reg <= fsu_sat16(dem_prod >>> LINES_LOG2);
      end
   end
   // fundamental frequency
   assign ramp_diff = 17'(normal_demand) - 17'(freq_out);
   assign step_s    = 17'(ramp_step);
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         freq_out <= '0;
      end else if (ctrl_reg.slave_en) begin
         freq_out <= slv_dem_reg;
      end else if (win_tick) begin
         if (ramp_diff > step_s) begin
            freq_out <= freq_out + 16'(ramp_step);
         end else if (ramp_diff < -step_s) begin
            freq_out <= freq_out - 16'(ramp_step);
         end else begin
            freq_out <= normal_demand;
         end
      end
   end
   // output pulse generator
   // edges run at 2 x f x mult; sized for the whole freq_out range up to 3276.7 Hz, at most one edge per clock
   assign freq_mag = freq_out[15] ? 16'(-freq_out) : 16'(freq_out);
   assign nco_inc  = ctrl_reg.mult
                     ? (28'(freq_mag) << `FSU_MULT_HI_SHIFT)
                     : (28'(freq_mag) << `FSU_MULT_LO_SHIFT);
   assign nco_sum  = nco_reg + 34'(nco_inc);
   assign reversal = (freq_out != 16'sh0000) && (freq_out[15] != dir_reg);
   assign edge_ev  = (gen_reg == fsu_pkg::FSU_GEN_RUN) && !reversal &&
                     (nco_sum >= NCO_LIM);
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         gen_reg     <= fsu_pkg::FSU_GEN_RUN;
         gap_cnt_reg <= '0;
         dir_reg     <= 1'b0;
         nco_reg     <= '0;
      end else begin
         case (gen_reg)
            fsu_pkg::FSU_GEN_RUN: begin
               if (reversal) begin
                  gen_reg     <= fsu_pkg::FSU_GEN_GAP;
                  gap_cnt_reg <= '0;
                  dir_reg     <= freq_out[15];
                  nco_reg     <= '0;
               end else if (edge_ev) begin
                  nco_reg <= nco_sum - NCO_LIM;
               end else begin
                  nco_reg <= nco_sum;
               end
            end
            fsu_pkg::FSU_GEN_GAP: begin
               if (gap_cnt_reg == GAP_W'(GAP_CYC - 1)) begin
                  gen_reg <= fsu_pkg::FSU_GEN_RUN;
               end
               gap_cnt_reg <= gap_cnt_reg + GAP_W'(1);
            end
            default: gen_reg <= fsu_pkg::FSU_GEN_RUN;
         endcase
      end
   end
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         quad_reg <= 2'h0;
         fd_reg   <= 1'b0;
      end else if (edge_ev) begin
         fd_reg   <= !fd_reg;
         quad_reg <= dir_reg ? quad_reg - 2'h1 : quad_reg + 2'h1;
      end
   end
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         pulse_out <= '0;
      end else if (!ctrl_reg.out_en) begin
         pulse_out <= '0;
      end else if (ctrl_reg.fmt) begin
         pulse_out.a <= fd_reg;
         pulse_out.b <= dir_reg;
      end else begin
         pulse_out.a <= quad_reg[1];
         pulse_out.b <= quad_reg[1] ^ quad_reg[0];
      end
   end
endmodule : fsu_top

// ==== verif/fsu_top_props.sv ====
// port checks for the frequency slaving unit
`timescale 1ns/1ps
`include "fsu_cfg.svh"
module fsu_top_props #(
   parameter int GAP_CYC = 50
) (
   input wire logic                   clk_sys,
   input wire logic                   arst_n,
   input wire logic                   s_axi_awvalid,
   input wire logic                   s_axi_awready,
   input wire logic                   s_axi_wvalid,
   input wire logic                   s_axi_wready,
   input wire logic [1:0]             s_axi_bresp,
   input wire logic                   s_axi_bvalid,
   input wire logic                   s_axi_arvalid,
   input wire logic                   s_axi_arready,
   input wire logic [31:0]            s_axi_rdata,
   input wire logic [1:0]             s_axi_rresp,
   input wire logic                   s_axi_rvalid,
   input wire logic                   s_axi_rready,
   input wire fsu_pkg::fsu_pulse_type pulse_out,
   input wire logic signed [15:0]     freq_out
);
   int   gap_cnt;
   logic last_neg;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   // zero is no direction, so only a change between nonzero signs counts
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         gap_cnt  <= 0;
         last_neg <= 1'h0;
      end else if (freq_out != 16'sh0 && freq_out[15] != last_neg) begin
         gap_cnt  <= GAP_CYC;
         last_neg <= freq_out[15];
      end else if (gap_cnt > 0) begin
         gap_cnt <= gap_cnt - 1;
      end
   end
   sequence s_both_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_resp_late;
      !s_axi_bvalid ##1 s_axi_bvalid;
   endsequence
   a_write_resp: assert property (s_both_taken |=> s_resp_late)
      else $error("write response not two edges after handshake");
   a_aw_blocked: assert property (s_axi_bvalid |->
      !s_axi_awready && !s_axi_wready)
      else $error("write channel ready while response pending");
   a_bresp_code: assert property (s_axi_bvalid |->
      s_axi_bresp inside {`FSU_RESP_OKAY, `FSU_RESP_SLVERR})
      else $error("illegal write response code");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid && !s_axi_arready)
      else $error("read data not right after address");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
      else $error("read data dropped before taken");
   a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address ready while data pending");
   a_reset_idle: assert property ($rose(arst_n) |-> s_axi_awready &&
      s_axi_arready && !s_axi_bvalid && !s_axi_rvalid && freq_out == 0)
      else $error("outputs not idle after reset");
   a_gap_quiet: assert property (
      gap_cnt > 3 && gap_cnt < GAP_CYC - 3 |-> $stable(pulse_out))
      else $error("output pulse inside reversal gap");
endmodule : fsu_top_props

// ==== verif/fsu_enc_src.sv ====
// pulse source standing in for another drive's slaving output
`timescale 1ns/1ps
module fsu_enc_src #(
   parameter int PER       = 4,
   parameter int SETUP_CYC = 500
) (
   input wire logic               clk_sys,
   input wire logic               arst_n,
   input wire logic               run,
   input wire logic               fd,
   input wire logic               rev,
   output fsu_pkg::fsu_pulse_type enc
);
   int         cnt_reg;
   int         hold_reg;
   logic [1:0] ph_reg;
   logic       dir_reg;
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         cnt_reg  <= 0;
         hold_reg <= 0;
         ph_reg   <= 2'h0;
         dir_reg  <= 1'h0;
      end else if (dir_reg != rev) begin
         dir_reg  <= rev;
         hold_reg <= SETUP_CYC;
      end else if (hold_reg > 0) begin
         hold_reg <= hold_reg - 1;
      end else if (run) begin
         cnt_reg <= (cnt_reg == PER - 1) ? 0 : cnt_reg + 1;
         if (cnt_reg == PER - 1) ph_reg <= ph_reg + (dir_reg ? 2'h3 : 2'h1);
      end
   end
   // quad walks 00 01 11 10; freq line toggles once per step
   assign enc.a = fd ? ph_reg[0] : ph_reg[1];
   assign enc.b = fd ? dir_reg : ph_reg[1] ^ ph_reg[0];
endmodule : fsu_enc_src

// ==== verif/fsu_top_bench.sv ====
// testbench for the frequency slaving unit
`timescale 1ns/1ps
`include "fsu_cfg.svh"
module fsu_top_bench;
   localparam int WIN = 200;
   localparam int GAP = 50;
   localparam logic [7:0] CTL = `FSU_ADDR_CTRL;
   localparam logic [7:0] DEM = `FSU_ADDR_SLV_DEMAND;
   localparam logic [1:0] OK = `FSU_RESP_OKAY;
   localparam logic [1:0] ERR = `FSU_RESP_SLVERR;
   logic               clk_sys = 1'h0, arst_n = 1'h0;
   logic [7:0]         awaddr = 8'h00, araddr = 8'h00;
   logic [31:0]        wdata = 32'h0, rdata, rd_val;
   logic               awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
   logic               arvalid = 1'h0, rready = 1'h0, drv_en = 1'h0;
   logic               awready, wready, bvalid, arready, rvalid;
   logic [1:0]         bresp, rresp, rd_resp;
   logic signed [15:0] norm_dem = 16'sh0000, freq_out;
   logic [15:0]        ramp = 16'h0000;
   logic               src_run = 1'h0, src_fd = 1'h0, src_rev = 1'h0;
   fsu_pkg::fsu_pulse_type enc, pout;
   int                 n_mismatch = 0, n_tests = 0, ca, cb, k;

   fsu_top #(.WIN_CYC(WIN), .GAP_CYC(GAP)) dut (
      .clk_sys(clk_sys), .arst_n(arst_n), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .drive_enable(drv_en),
      .normal_demand(norm_dem), .ramp_step(ramp), .enc_in(enc),
      .pulse_out(pout), .freq_out(freq_out));
   fsu_enc_src src (.clk_sys(clk_sys), .arst_n(arst_n), .run(src_run),
      .fd(src_fd), .rev(src_rev), .enc(enc));

   always #10 clk_sys = ~clk_sys;

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic rng(input int v, input int lo, input int hi);
      chk({31'h0, v >= lo && v <= hi}, 32'h1);
   endtask : rng
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : cyc
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er);
      @(posedge clk_sys);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'h1;
      wvalid  <= 1'h1;
      bready  <= 1'h1;
      forever begin
         @(posedge clk_sys);
         if (awready) awvalid <= 1'h0;
         if (wready) wvalid <= 1'h0;
         if (bvalid) begin
            bready <= 1'h0;
            chk({30'h0, bresp}, {30'h0, er});
            break;
         end
      end
   endtask : wr
   // rready comes late on purpose so the data must stand while unread
   task automatic rd(input logic [7:0] a);
      @(posedge clk_sys);
      araddr  <= a;
      arvalid <= 1'h1;
      forever begin
         @(posedge clk_sys);
         if (arready) arvalid <= 1'h0;
         if (rvalid && rready) begin
            rready  <= 1'h0;
            rd_val  = rdata;
            rd_resp = rresp;
            break;
         end
         if (!arvalid) rready <= 1'h1;
      end
   endtask : rd
   task automatic rdc(input logic [7:0] a, input logic [31:0] d);
      rd(a);
      chk(rd_val, d);
      chk({30'h0, rd_resp}, {30'h0, OK});
   endtask : rdc
   task automatic cnt(input int n);
      fsu_pkg::fsu_pulse_type p;
      ca = 0;
      cb = 0;
      // skip the edge that applies a new mode, so only rate toggles count
      @(posedge clk_sys);
      p = pout;
      repeat (n) begin
         @(posedge clk_sys);
         ca += int'(pout.a !== p.a);
         cb += int'(pout.b !== p.b);
         p = pout;
      end
   endtask : cnt

   task automatic t_regs;
      rdc(CTL, 32'h0);
      rdc(`FSU_ADDR_NUM, 32'h3e8);
      rdc(`FSU_ADDR_DEN, 32'h3e8);
      rd(8'h20);
      chk({30'h0, rd_resp}, {30'h0, ERR});
      wr(`FSU_ADDR_FREQ_OUT, 32'h5, ERR);
      wr(`FSU_ADDR_NUM, 32'h2, OK);
      wr(`FSU_ADDR_DEN, 32'h0, OK);
      rdc(`FSU_ADDR_DEN, 32'h0);
   endtask : t_regs
   // quad source gives 50 counts a window; demand = n * 2500 >> 12
   task automatic t_input;
      @(posedge clk_sys);
      src_run <= 1'h1;
      cyc(2 * WIN);
      rdc(DEM, 32'h0);
      @(posedge clk_sys);
      drv_en <= 1'h1;
      cyc(4 * WIN);
      rdc(DEM, 32'h3d);
      wr(`FSU_ADDR_DEN, 32'h3e8, OK);
      wr(`FSU_ADDR_NUM, 32'h3e8, OK);
      cyc(3 * WIN);
      rdc(DEM, 32'h1e);
      wr(`FSU_ADDR_NUM, 32'h1f4, OK);
      cyc(3 * WIN);
      rdc(DEM, 32'hf);
      wr(`FSU_ADDR_NUM, 32'h3e8, OK);
      wr(CTL, 32'h10, OK);
      @(posedge clk_sys);
      src_fd  <= 1'h1;
      src_rev <= 1'h1;
      cyc(6 * WIN);
      rd(DEM);
      chk({31'h0, rd_val inside {32'hfffffff0, 32'hfffffff1}}, 32'h1);
      @(posedge clk_sys);
      drv_en <= 1'h0;
      cyc(3);
      rdc(DEM, 32'h0);
   endtask : t_input
   // slaved 3.0 Hz against a zero demand keeps the step small
   task automatic t_slave;
      @(posedge clk_sys);
      drv_en  <= 1'h1;
      src_fd  <= 1'h0;
      src_rev <= 1'h0;
      ramp    <= 16'h0001;
      wr(CTL, 32'h0, OK);
      cyc(6 * WIN);
      wr(CTL, 32'h1, OK);
      cyc(2);
      chk(32'(freq_out), 32'h1e);
      wr(CTL, 32'h0, OK);
      cyc(2);
      chk({31'h0, freq_out > 28}, 32'h1);
      cyc(2 * WIN);
      chk({31'h0, freq_out >= 26 && freq_out <= 28}, 32'h1);
   endtask : t_slave
   // 100.0 Hz times 4096 over 10000 clocks gives 81.92 edge events
   task automatic t_output;
      logic p0;
      @(posedge clk_sys);
      ramp     <= 16'h1000;
      norm_dem <= 16'sh03e8;
      cyc(2 * WIN);
      chk(32'(freq_out), 32'h3e8);
      chk({30'h0, pout}, 32'h0);
      wr(CTL, 32'he, OK);
      cnt(10000);
      rng(ca, 81, 82);
      rng(cb, 0, 0);
      wr(CTL, 32'h6, OK);
      cnt(10000);
      rng(ca + cb, 81, 83);
      rng(ca, 40, 42);
      wr(CTL, 32'ha, OK);
      cnt(10000);
      rng(ca, 0, 1);
      wr(CTL, 32'he, OK);
      @(posedge clk_sys);
      norm_dem <= -16'sh03e8;
      for (k = 0; k < 3 * WIN && freq_out[15] !== 1'h1; k++) cyc(1);
      cyc(3);
      p0 = pout.a;
      for (k = 0; k < 400 && pout.a === p0; k++) cyc(1);
      rng(k, GAP - 5, GAP + 200);
      chk({31'h0, pout.b}, 32'h1);
      wr(CTL, 32'h0, OK);
      cyc(2);
      chk({30'h0, pout}, 32'h0);
   endtask : t_output

   task automatic final_report;
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : final_report

   initial begin
      repeat (6) @(posedge clk_sys);
      arst_n <= 1'h1;
      t_regs();
      t_input();
      t_slave();
      t_output();
      final_report();
   end
   initial begin
      #2000000;
      n_mismatch++;
      final_report();
   end
endmodule : fsu_top_bench

bind fsu_top fsu_top_props #(.GAP_CYC(GAP_CYC)) u_props (
   .clk_sys(clk_sys), .arst_n(arst_n), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .pulse_out(pulse_out),
   .freq_out(freq_out));
